/* File: logic/timer_cfg.svh */
/*
 * Constants of the capture/compare/PWM timer: register byte offsets,
 * field positions, reset values and counter end values.
 * Assumes an APB slave with 32-bit data, one register per aligned word.
 */
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH

`define N_CH            2
// Byte offsets (word aligned)
`define A_TSC           12'h000
`define A_CNTH          12'h004
`define A_CNTL          12'h008
`define A_MODH          12'h00C
`define A_MODL          12'h010
`define A_CH_BASE       12'h020
`define A_CH_STRIDE     12'h010
`define A_CSC           12'h000
`define A_CVH           12'h004
`define A_CVL           12'h008
// Timer control fields
`define TSC_FLAG        7
`define TSC_IRQEN       6
`define TSC_CPWM        5
`define TSC_CLK_HI      4
`define TSC_CLK_LO      3
// Channel control fields
`define CSC_FLAG        7
`define CSC_IE          6
`define CSC_MB          5
`define CSC_MA          4
`define CSC_ELB         3
`define CSC_ELA         2
// Values
`define ZERO16          16'h0000
`define ONE16           16'h0001
`define ALL16           16'hFFFF
`define RST8            8'h00
`define RST_CLK         2'b00

`endif

/* File: logic/timer_pkg.sv */
/*
 * Types shared by the timer files.
 * Assumes timer_cfg.svh is on the include path.
 */
`default_nettype none
package timer_pkg;
	typedef enum logic [1:0] {
		SRC_OFF   = 2'b00,
		SRC_BUS   = 2'b01,
		SRC_FIXED = 2'b10,
		SRC_EXT   = 2'b11
	} count_source_t;
	typedef enum logic [1:0] {
		CH_CAPTURE = 2'b00,
		CH_COMPARE = 2'b01,
		CH_EPWM    = 2'b11,
		CH_CPWM    = 2'b10
	} ch_mode_t;
endpackage
`default_nettype wire

/* File: logic/timer_channel.sv */
/*
 * One timer channel: capture, compare, edge and centre PWM, with its
 * value register, write buffer, read latch and event flag.
 * Assumes a counter, direction and tick from the parent, same clock.
 */
`default_nettype none
`include "timer_cfg.svh"
module timer_channel (
	input  wire logic                ref_clk,
	input  wire logic                arst_n,
	input  wire logic                tick,
	input  wire logic [15:0]         count,
	input  wire logic                count_down,
	input  wire logic                period_end,
	input  wire logic                cpwm,
	input  wire logic                pin_sync,
	input  wire logic                csc_wr,
	input  wire logic                csc_rd,
	input  wire logic [7:0]          wdata,
	input  wire logic                vh_wr,
	input  wire logic                vl_wr,
	input  wire logic                vh_rd,
	input  wire logic                vl_rd,
	output logic [7:0]               csc_q,
	output logic [7:0]               vh_q,
	output logic [7:0]               vl_q,
	output logic                     pin_out,
	output logic                     pin_oe,
	output logic                     irq
);
	import timer_pkg::*;
	// =============================================
	// Mode decode
	logic [7:0]  ctl_r;
	logic        flag_r, armed_r, pin_r, pin_d_r;
	logic [15:0] val_r, buf_r, rlat_r;
	logic        bh_r, bl_r, rl_r;
	wire  [1:0]  els      = ctl_r[`CSC_ELB:`CSC_ELA];
	wire         is_cap   = !cpwm && !ctl_r[`CSC_MB] && !ctl_r[`CSC_MA];
	wire         is_cmp   = !cpwm && !ctl_r[`CSC_MB] && ctl_r[`CSC_MA];
	wire         is_epwm  = !cpwm && ctl_r[`CSC_MB];
	wire         is_pwm   = is_epwm || cpwm;
	wire         rise     = pin_sync && !pin_d_r;
	wire         fall     = !pin_sync && pin_d_r;
	wire         cap_ev   = is_cap && ((els[0] && rise) || (els[1] && fall));
	wire         match    = tick && (count == val_r);
	wire         cmp_ev   = !is_cap && match;
	wire         ev       = cap_ev || cmp_ev;
	wire         both     = (bh_r || vh_wr) && (bl_r || vl_wr);
	wire [15:0]  buf_nxt  = {vh_wr ? wdata : buf_r[15:8], vl_wr ? wdata : buf_r[7:0]};
	// Compare loads at once, edge PWM at count zero, centre PWM at reversal
	wire         ld_ok    = is_cmp || (is_epwm && tick && count == `ZERO16)
	                        || (cpwm && period_end);
	wire         load     = !is_cap && both && ld_ok;
	wire         clr_flag = csc_wr && armed_r && !wdata[`CSC_FLAG];
	wire         cpwm_zero = val_r == `ZERO16 || val_r[15];
	logic        pin_nxt;
	always_comb begin
		pin_nxt = pin_r;
		if (is_cmp && match) begin
			case (els)
				2'b01:   pin_nxt = !pin_r;
				2'b10:   pin_nxt = 1'b0;
				2'b11:   pin_nxt = 1'b1;
				default: pin_nxt = pin_r;
			endcase
		end else if (is_epwm && tick) begin
			if (count == `ZERO16)
				pin_nxt = (val_r == `ZERO16) ? els[0] : !els[0];
			else if (count == val_r)
				pin_nxt = els[0];
		end else if (cpwm && tick) begin
			if (cpwm_zero)
				pin_nxt = els[0];
			else if (count == val_r)
				pin_nxt = count_down ? !els[0] : els[0];
		end
	end
	// =============================================
	// Registers
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctl_r   <= `RST8;
			flag_r  <= 1'b0;
			armed_r <= 1'b0;
			pin_r   <= 1'b0;
			pin_d_r <= 1'b0;
			val_r   <= `ZERO16;
			buf_r   <= `ZERO16;
			rlat_r  <= `ZERO16;
			bh_r    <= 1'b0;
			bl_r    <= 1'b0;
			rl_r    <= 1'b0;
		end else begin
			pin_d_r <= pin_sync;
			pin_r   <= pin_nxt;
			if (csc_wr)
				ctl_r <= {1'b0, wdata[6:0]};
			// Set wins over clear; a new event also disarms the read-then-write clear
			if (ev)
				flag_r <= 1'b1;
			else if (clr_flag)
				flag_r <= 1'b0;
			if (ev || csc_wr)
				armed_r <= 1'b0;
			if (csc_rd && flag_r && !ev)
				armed_r <= 1'b1;
			if (cap_ev)
				val_r <= count;
			else if (load)
				val_r <= buf_nxt;
			// Write buffer pairing, cancelled by a control write
			if (csc_wr || load) begin
				bh_r <= 1'b0;
				bl_r <= 1'b0;
			end else begin
				bh_r <= bh_r || vh_wr;
				bl_r <= bl_r || vl_wr;
			end
			if (vh_wr || vl_wr)
				buf_r <= buf_nxt;
			// Capture read latch
			if (csc_wr)
				rl_r <= 1'b0;
			else if (is_cap && (vh_rd || vl_rd)) begin
				rl_r <= !rl_r;
				if (!rl_r)
					rlat_r <= val_r;
			end
		end
	end
	wire [15:0] rd_val = (is_cap && rl_r) ? rlat_r : val_r;
	assign vh_q    = rd_val[15:8];
	assign vl_q    = rd_val[7:0];
	assign csc_q   = {flag_r, ctl_r[6:0]};
	assign pin_out = pin_r;
	assign pin_oe  = (els != 2'b00) && !is_cap;
	assign irq     = flag_r && ctl_r[`CSC_IE];

	// =============================================
	// Checks
	property p_release;
		@(posedge ref_clk) disable iff (!arst_n) (els == 2'b00) |-> !pin_oe;
	endproperty
	a_release: assert property (p_release) else $error("pin driven while released");
	property p_cap;
		@(posedge ref_clk) disable iff (!arst_n) cap_ev |=> (val_r == $past(count)) && flag_r;
	endproperty
	a_cap: assert property (p_cap) else $error("capture not stored");
	property p_set;
		@(posedge ref_clk) disable iff (!arst_n)
		(is_cmp && match && els == 2'b11) |=> pin_out;
	endproperty
	a_set: assert property (p_set) else $error("compare set failed");
	property p_flag_hold;
		@(posedge ref_clk) disable iff (!arst_n) (csc_wr && !armed_r && flag_r) |=> flag_r;
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag cleared unarmed");
	property p_pair;
		@(posedge ref_clk) disable iff (!arst_n)
		(!both && !cap_ev) |=> val_r == $past(val_r);
	endproperty
	a_pair: assert property (p_pair) else $error("value moved without pair");
endmodule // timer_channel
`default_nettype wire

/* File: logic/timer_capture_compare_pwm.sv */
/*
 * Sixteen-bit timer with modulus counter and capture/compare/PWM channels,
 * reached over APB with byte registers in the low bits of each word.
 * Assumes ref_clk is the bus clock; timer pins and modes come from outside.
 *
 * // What this block does
 * // Select 00 releases the channel pin
 * // Capture on rising, falling or either edge
 * // Compare: none, toggle, clear or set pin
 * // Edge PWM high-true or low-true pulses
 * // Centre PWM polarity set by select
 * // Software keeps pin stable before capture
 * // Software clears flags after reconfiguring
 * // Channel value holds capture or compare, reset clears
 * // Capture read latches both bytes
 * // Channel writes paired in buffer, control resets
 * // Centre-align forces up/down and all channels
 * // Count source resets off; 01 is bus clock
 * // External clock at most quarter bus rate
 * // Counter halts in debug and stop
 * // Up count zero to terminal then zero
 * // Up/down count, one tick at ends
 * // Wrap interrupt is flag and enable level
 * // Up mode wrap flag at terminal to zero
 * // Up/down wrap flag at reversal from modulus
 * // Counter byte read snapshots both bytes
 * // Counter write clears count and snapshot
 * // Event flag set; read-then-write-zero clears
 * // Edge PWM loads value at count zero
 * // Counter and values as high/low bytes
 */
`default_nettype none
`include "timer_cfg.svh"
module timer_capture_compare_pwm (
	input  wire logic                ref_clk,
	input  wire logic                arst_n,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	output logic [31:0]              prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic                debug_halt,
	input  wire logic                stop_mode,
	input  wire logic                fixed_clk_tick,
	input  wire logic                ext_clk_pin,
	input  wire logic [`N_CH-1:0]    ch_pin_in,
	output logic [`N_CH-1:0]         ch_pin_out,
	output logic [`N_CH-1:0]         ch_pin_oe,
	output logic                     wrap_irq,
	output logic [`N_CH-1:0]         ch_irq
);
	import timer_pkg::*;
	// =============================================
	// Pin synchronisers
	logic [`N_CH+1:0] s1_r, s2_r;
	logic             fix_d_r, ext_d_r;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			s1_r <= '0;
			s2_r <= '0;
		end else begin
			s1_r <= {fixed_clk_tick, ext_clk_pin, ch_pin_in};
			s2_r <= s1_r;
		end
	end
	wire [`N_CH-1:0] ch_sync  = s2_r[`N_CH-1:0];
	wire             ext_sync = s2_r[`N_CH];
	wire             fix_sync = s2_r[`N_CH+1];

	// =============================================
	// Bus decode
	wire        acc     = psel && penable;
	wire        wr      = acc && pwrite;
	wire        rd      = acc && !pwrite;
	wire [7:0]  wb      = pwdata[7:0];
	wire        hit_tsc = paddr == `A_TSC;
	wire        hit_ch  = paddr == `A_CNTH;
	wire        hit_cl  = paddr == `A_CNTL;
	wire        hit_mh  = paddr == `A_MODH;
	wire        hit_ml  = paddr == `A_MODL;

	// =============================================
	// Timer control and counter
	logic [7:0]  tsc_r;
	logic [15:0] cnt_r, mod_r, modbuf_r, snap_r;
	logic        down_r, tof_r, tof_arm_r, snap_r_v, mbh_r, mbl_r;
	count_source_t src;
	assign src = count_source_t'(tsc_r[`TSC_CLK_HI:`TSC_CLK_LO]);
	wire cpwm = tsc_r[`TSC_CPWM];
	logic src_tick;
	always_comb begin
		case (src)
			SRC_OFF:   src_tick = 1'b0;
			SRC_BUS:   src_tick = 1'b1;
			SRC_FIXED: src_tick = fix_sync && !fix_d_r;
			SRC_EXT:   src_tick = ext_sync && !ext_d_r;
			default:   src_tick = 1'b0;
		endcase
	end
	wire        tick     = src_tick && !debug_halt && !stop_mode;
	wire [15:0] term     = (mod_r == `ZERO16) ? `ALL16 : mod_r;
	wire        at_term  = cnt_r == term;
	wire        up_wrap  = tick && !cpwm && at_term;
	wire        reverse  = tick && cpwm && !down_r && at_term;
	wire        wrap_ev  = up_wrap || reverse;
	wire        cnt_wr   = wr && (hit_ch || hit_cl);
	wire        cnt_rd   = rd && (hit_ch || hit_cl);
	wire        tsc_wr   = wr && hit_tsc;
	wire        tof_clr  = tsc_wr && tof_arm_r && !wb[`TSC_FLAG];
	wire        mboth    = (mbh_r || (wr && hit_mh)) && (mbl_r || (wr && hit_ml));
	wire [15:0] mod_nxt  = {(wr && hit_mh) ? wb : modbuf_r[15:8],
	                        (wr && hit_ml) ? wb : modbuf_r[7:0]};
	logic [15:0] cnt_nxt;
	logic        down_nxt;
	always_comb begin
		cnt_nxt  = cnt_r;
		down_nxt = down_r;
		if (!cpwm)
			down_nxt = 1'b0;
		if (cnt_wr) begin
			cnt_nxt  = `ZERO16;
			down_nxt = 1'b0;
		end else if (tick) begin
			if (!cpwm)
				cnt_nxt = at_term ? `ZERO16 : cnt_r + `ONE16;
			else if (!down_r) begin
				// Terminal value lasts one tick, then step down
				cnt_nxt  = at_term ? cnt_r - `ONE16 : cnt_r + `ONE16;
				down_nxt = at_term;
			end else begin
				cnt_nxt  = (cnt_r == `ONE16) ? `ZERO16 : cnt_r - `ONE16;
				down_nxt = cnt_r != `ONE16;
			end
		end
	end
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			tsc_r     <= `RST8;
			cnt_r     <= `ZERO16;
			down_r    <= 1'b0;
			fix_d_r   <= 1'b0;
			ext_d_r   <= 1'b0;
		end else begin
			fix_d_r <= fix_sync;
			ext_d_r <= ext_sync;
			cnt_r   <= cnt_nxt;
			down_r  <= down_nxt;
			if (tsc_wr)
				tsc_r <= {1'b0, wb[6:0]};
		end
	end
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			tof_r     <= 1'b0;
			tof_arm_r <= 1'b0;
			mod_r     <= `ZERO16;
			modbuf_r  <= `ZERO16;
			mbh_r     <= 1'b0;
			mbl_r     <= 1'b0;
		end else begin
			if (wrap_ev)
				tof_r <= 1'b1;
			else if (tof_clr)
				tof_r <= 1'b0;
			if (wrap_ev || tsc_wr)
				tof_arm_r <= 1'b0;
			if (rd && hit_tsc && tof_r && !wrap_ev)
				tof_arm_r <= 1'b1;
			if (wr && (hit_mh || hit_ml))
				modbuf_r <= mod_nxt;
			// Modulus moves after both bytes, at reversal in centre mode
			if (mboth && (!cpwm || reverse)) begin
				mod_r <= mod_nxt;
				mbh_r <= 1'b0;
				mbl_r <= 1'b0;
			end else if (tsc_wr) begin
				mbh_r <= 1'b0;
				mbl_r <= 1'b0;
			end else begin
				mbh_r <= mbh_r || (wr && hit_mh);
				mbl_r <= mbl_r || (wr && hit_ml);
			end
		end
	end
	// Counter read snapshot
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			snap_r   <= `ZERO16;
			snap_r_v <= 1'b0;
		end else if (cnt_wr) begin
			snap_r_v <= 1'b0;
		end else if (cnt_rd) begin
			snap_r_v <= !snap_r_v;
			if (!snap_r_v)
				snap_r <= cnt_r;
		end
	end
	wire [15:0] cnt_view = snap_r_v ? snap_r : cnt_r;
	assign wrap_irq = tof_r && tsc_r[`TSC_IRQEN];

	// =============================================
	// Channels
	wire [7:0] csc_q [`N_CH];
	wire [7:0] vh_q  [`N_CH];
	wire [7:0] vl_q  [`N_CH];
	wire [`N_CH-1:0] ch_sel;
	genvar g;
	generate
		for (g = 0; g < `N_CH; g++) begin : g_ch
			localparam logic [11:0] BASE = `A_CH_BASE + 12'(g) * `A_CH_STRIDE;
			wire sel_c = paddr == BASE + `A_CSC;
			wire sel_h = paddr == BASE + `A_CVH;
			wire sel_l = paddr == BASE + `A_CVL;
			assign ch_sel[g] = sel_c || sel_h || sel_l;
			timer_channel u_ch (
				.ref_clk    (ref_clk),
				.arst_n     (arst_n),
				.tick       (tick),
				.count      (cnt_r),
				.count_down (down_r),
				.period_end (reverse),
				.cpwm       (cpwm),
				.pin_sync   (ch_sync[g]),
				.csc_wr     (wr && sel_c),
				.csc_rd     (rd && sel_c),
				.wdata      (wb),
				.vh_wr      (wr && sel_h),
				.vl_wr      (wr && sel_l),
				.vh_rd      (rd && sel_h),
				.vl_rd      (rd && sel_l),
				.csc_q      (csc_q[g]),
				.vh_q       (vh_q[g]),
				.vl_q       (vl_q[g]),
				.pin_out    (ch_pin_out[g]),
				.pin_oe     (ch_pin_oe[g]),
				.irq        (ch_irq[g])
			);
		end
	endgenerate

	// =============================================
	// Read mux
	logic [7:0] rbyte;
	logic       mapped;
	always_comb begin
		rbyte  = `RST8;
		mapped = hit_tsc || hit_ch || hit_cl || hit_mh || hit_ml || (|ch_sel);
		if (hit_tsc)
			rbyte = {tof_r, tsc_r[6:0]};
		else if (hit_ch)
			rbyte = cnt_view[15:8];
		else if (hit_cl)
			rbyte = cnt_view[7:0];
		else if (hit_mh)
			rbyte = mod_r[15:8];
		else if (hit_ml)
			rbyte = mod_r[7:0];
		for (int i = 0; i < `N_CH; i++) begin
			if (paddr == `A_CH_BASE + 12'(i) * `A_CH_STRIDE + `A_CSC)
				rbyte = csc_q[i];
			else if (paddr == `A_CH_BASE + 12'(i) * `A_CH_STRIDE + `A_CVH)
				rbyte = vh_q[i];
			else if (paddr == `A_CH_BASE + 12'(i) * `A_CH_STRIDE + `A_CVL)
				rbyte = vl_q[i];
		end
	end
	assign prdata  = {24'h00_0000, rbyte};
	assign pready  = 1'b1;
	assign pslverr = acc && !mapped;

	// =============================================
	// Checks
	sequence s_at_mod_up;
		tick && cpwm && !down_r && at_term;
	endsequence
	property p_rev_flag;
		@(posedge ref_clk) disable iff (!arst_n) s_at_mod_up ##1 1'b1 |-> tof_r && down_r;
	endproperty
	a_rev_flag: assert property (p_rev_flag) else $error("no wrap at reversal");
	property p_up_wrap;
		@(posedge ref_clk) disable iff (!arst_n)
		(up_wrap && !cnt_wr) |=> cnt_r == `ZERO16 && tof_r;
	endproperty
	a_up_wrap: assert property (p_up_wrap) else $error("up wrap wrong");
	property p_irq;
		@(posedge ref_clk) disable iff (!arst_n) wrap_irq == (tof_r && tsc_r[`TSC_IRQEN]);
	endproperty
	a_irq: assert property (p_irq) else $error("irq level wrong");
	property p_clr;
		@(posedge ref_clk) disable iff (!arst_n) cnt_wr |=> cnt_r == `ZERO16 && !snap_r_v;
	endproperty
	a_clr: assert property (p_clr) else $error("counter write not clearing");
	property p_halt;
		@(posedge ref_clk) disable iff (!arst_n)
		(debug_halt && !cnt_wr) |=> cnt_r == $past(cnt_r);
	endproperty
	a_halt: assert property (p_halt) else $error("counted in debug");
	property p_off;
		@(posedge ref_clk) disable iff (!arst_n)
		(src == SRC_OFF && !cnt_wr) |=> $stable(cnt_r);
	endproperty
	a_off: assert property (p_off) else $error("counted with no source");
	property p_snap;
		@(posedge ref_clk) disable iff (!arst_n)
		(cnt_rd && !snap_r_v) |=> snap_r_v && snap_r == $past(cnt_r);
	endproperty
	a_snap: assert property (p_snap) else $error("snapshot missing");
endmodule // timer_capture_compare_pwm
`default_nettype wire

/* File: testbench/pin_partner.sv */
/*
 * Far side of the timer pins: outside levels on the channel pins and
 * a free-running count clock at a quarter of the bus rate.
 * Assumes the bench sets lvl; the design's enables win on each pin.
 */
`default_nettype none
`include "timer_cfg.svh"
module pin_partner (
	input  wire logic             ref_clk,
	input  wire logic [`N_CH-1:0] lvl,
	input  wire logic [`N_CH-1:0] pin_out,
	input  wire logic [`N_CH-1:0] pin_oe,
	output logic      [`N_CH-1:0] pin_in,
	output logic                  ext_clk
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] div_r = 2'b00;
	// ==========
	// Wire level and count clock
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & lvl);
	always @(posedge ref_clk) div_r <= div_r + 2'b01;
	assign ext_clk = div_r[1];
endmodule // pin_partner
`default_nettype wire

/* File: testbench/tb_timer_capture_compare_pwm.sv */
/*
 * Self-checking bench of the timer: APB master, integer expectations.
 * Assumes timer_cfg.svh on the include path and zero-wait APB answers.
 */
`default_nettype none
`include "timer_cfg.svh"
module tb_timer_capture_compare_pwm;
	timeunit 1ns;
	timeprecision 1ps;
	logic              ref_clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic              debug_halt = 0, stop_mode = 0, pready, pslverr, wrap_irq, ext_clk;
	logic              eq, pb;
	logic [11:0]       paddr = 0;
	logic [31:0]       pwdata = 0, prdata;
	logic [`N_CH-1:0]  lvl = 0, pin_in, pin_out, pin_oe, ch_irq;
	logic [7:0]        rq;
	logic [15:0]       x, k;
	int                bad_count = 0, compares = 0, m, v, h, w;
	int unsigned       seed = 83;
	// ==========
	// Clock, design and partner
	initial forever #2 ref_clk = ~ref_clk;
	timer_capture_compare_pwm i_timer_capture_compare_pwm (.ref_clk(ref_clk), .arst_n(arst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .debug_halt(debug_halt),
		.stop_mode(stop_mode), .fixed_clk_tick(ext_clk), .ext_clk_pin(ext_clk),
		.ch_pin_in(pin_in), .ch_pin_out(pin_out), .ch_pin_oe(pin_oe), .wrap_irq(wrap_irq),
		.ch_irq(ch_irq));
	pin_partner i_pin_partner (.ref_clk(ref_clk), .lvl(lvl), .pin_out(pin_out),
		.pin_oe(pin_oe), .pin_in(pin_in), .ext_clk(ext_clk));
	// ==========
	// Helpers
	function automatic int rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return int'(seed & 32'h0000_FFFF);
	endfunction
	function automatic logic [11:0] ca(input int ch, input logic [11:0] off);
		return 12'(`A_CH_BASE + ch * `A_CH_STRIDE) + off;
	endfunction
	function automatic int tsc(input int ie, input int cp, input int src);
		return (ie << `TSC_IRQEN) | (cp << `TSC_CPWM) | (src << `TSC_CLK_LO);
	endfunction
	function automatic int csc(input int md, input int sel);
		return (1 << `CSC_IE) | (md << `CSC_MA) | (sel << `CSC_ELA);
	endfunction
	task automatic tally_and_finish();
		$display("bad_count %0d compares %0d", bad_count, compares);
		if (bad_count == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %s exp %0h seen %0h", nm, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic apb(input logic wr_en, input logic [11:0] a, input int d);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel    <= 1'b1;
		pwrite  <= wr_en;
		paddr   <= a;
		pwdata  <= 32'(d & 255);
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		if (n >= 64) begin
			bad_count++;
			tally_and_finish();
		end
		rq = prdata[7:0];
		eq = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input int d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a);
		apb(1'b0, a, 0);
	endtask
	task automatic rdc();
		rd(`A_CNTH);
		x[15:8] = rq;
		rd(`A_CNTL);
		x[7:0] = rq;
	endtask
	task automatic highs(input int n, output int c);
		c = 0;
		repeat (n) begin
			@(posedge ref_clk);
			c += (pin_out[0] === 1'b1);
		end
	endtask
	// ==========
	// Main sequence
	initial begin
		cyc(4);
		arst_n <= 1'b1;
		rd(`A_TSC);
		chk("tsc_rst", rq, 0);
		rd(ca(0, `A_CVH));
		chk("cvh_rst", rq, 0);
		rd(12'h7F0);
		chk("unmapped", {eq, rq}, 9'h100);
		for (int s = 1; s < 4; s++) begin
			wr(`A_TSC, tsc(0, 0, s));
			wr(`A_CNTL, 8'h5A);
			cyc(400);
			debug_halt <= 1'b1;
			cyc(3);
			rdc();
			k = x;
			cyc(20);
			rdc();
			chk("halt_hold", x, k);
			h = (s == 1) ? 404 : 101;
			chk("src_rate", (k > h - 10 && k < h + 10), 1);
			debug_halt <= 1'b0;
		end
		stop_mode <= 1'b1;
		cyc(3);
		rdc();
		k = x;
		cyc(40);
		rdc();
		chk("stop_hold", x, k);
		stop_mode <= 1'b0;
		wr(`A_TSC, 0);
		wr(`A_CNTH, 8'h33);
		rdc();
		chk("cnt_clear", x, 0);
		wr(`A_TSC, tsc(0, 0, 1));
		debug_halt <= 1'b1;
		cyc(3);
		rdc();
		k = x;
		rd(`A_CNTL);
		debug_halt <= 1'b0;
		cyc(600);
		rd(`A_CNTH);
		chk("snap_hi", rq, k[15:8]);
		rd(`A_CNTH);
		chk("snap_new", rq != k[15:8], 1);
		rd(`A_CNTL);
		m = 8 + rnd() % 24;
		wr(`A_TSC, 0);
		wr(`A_MODH, 0);
		wr(`A_MODL, m);
		wr(`A_CNTL, 0);
		wr(`A_TSC, tsc(0, 0, 1));
		for (int i = 0; i < 8; i++) begin
			cyc(rnd() % 13);
			rdc();
			chk("up_range", x <= m, 1);
		end
		chk("irq_off", wrap_irq, 0);
		debug_halt <= 1'b1;
		rd(`A_TSC);
		chk("wrap_flag", rq[`TSC_FLAG], 1);
		wr(`A_TSC, tsc(1, 0, 1));
		cyc(1);
		chk("irq_clr", wrap_irq, 0);
		debug_halt <= 1'b0;
		cyc(m + 4);
		chk("irq_on", wrap_irq, 1);
		debug_halt <= 1'b1;
		rd(`A_TSC);
		wr(`A_TSC, tsc(0, 1, 1));
		debug_halt <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			cyc(rnd() % 13);
			rdc();
			chk("ud_range", x <= m, 1);
		end
		cyc(2 * m + 4);
		rd(`A_TSC);
		chk("ud_flag", rq[`TSC_FLAG], 1);
		v = 1 + rnd() % (m - 1);
		for (int s = 1; s < 3; s++) begin
			wr(ca(0, `A_CSC), csc(1, s));
			wr(ca(0, `A_CVL), v);
			wr(ca(0, `A_CVH), 0);
			cyc(4 * m);
			highs(2 * m, h);
			if (s == 1)
				w = h;
		end
		chk("cpwm_oe", pin_oe[0], 1);
		chk("cpwm_sum", h + w, 2 * m);
		chk("cpwm_width", h >= 2 * v - 2 && h <= 2 * v + 2, 1);
		wr(`A_TSC, tsc(0, 0, 1));
		for (int s = 0; s < 4; s++) begin
			wr(ca(0, `A_CSC), csc(1, s));
			wr(ca(0, `A_CVH), 0);
			wr(ca(0, `A_CVL), v);
			rd(ca(0, `A_CVL));
			chk("cmp_val", rq, v);
			cyc(m + 3);
			chk("cmp_oe", pin_oe[0], s != 0);
			pb = pin_out[0];
			cyc(m + 1);
			chk("cmp_pin", pin_out[0], s == 1 ? !pb : s == 2 ? 0 : s == 3 ? 1 : pb);
		end
		wr(ca(0, `A_CVH), 1);
		wr(ca(0, `A_CSC), csc(1, 1));
		wr(ca(0, `A_CVL), v);
		rd(ca(0, `A_CVH));
		chk("cv_cancel", rq, 0);
		debug_halt <= 1'b1;
		rd(ca(0, `A_CSC));
		wr(ca(0, `A_CSC), csc(1, 1));
		wr(ca(0, `A_CSC), csc(1, 1) | 128);
		cyc(1);
		chk("chf_clr", ch_irq[0], 0);
		debug_halt <= 1'b0;
		cyc(m + 3);
		chk("chf_set", ch_irq[0], 1);
		for (int s = 1; s < 3; s++) begin
			for (int j = 0; j < 3; j++) begin
				v = (j == 0) ? 0 : (j == 1) ? m / 2 : 255;
				wr(ca(0, `A_CSC), csc(2, s));
				wr(ca(0, `A_CVL), v);
				wr(ca(0, `A_CVH), 0);
				cyc(3 * m);
				highs(m + 1, h);
				w = (v > m) ? m + 1 : v;
				chk("epwm_high", h, s == 2 ? w : m + 1 - w);
			end
		end
		debug_halt <= 1'b1;
		cyc(3);
		rdc();
		for (int s = 1; s < 4; s++) begin
			lvl[1] <= 1'b0;
			cyc(4);
			wr(ca(1, `A_CSC), csc(0, s));
			rd(ca(1, `A_CSC));
			wr(ca(1, `A_CSC), csc(0, s));
			lvl[1] <= 1'b1;
			cyc(6);
			chk("cap_rise", ch_irq[1], s & 1);
			rd(ca(1, `A_CSC));
			wr(ca(1, `A_CSC), csc(0, s));
			lvl[1] <= 1'b0;
			cyc(6);
			chk("cap_fall", ch_irq[1], s >> 1);
			rd(ca(1, `A_CVL));
			chk("cap_val", rq, x[7:0]);
		end
		tally_and_finish();
	end
endmodule // tb_timer_capture_compare_pwm
`default_nettype wire
